// File: hdl/psi_code_decode.v
// Post status indicator: progress byte to boot phase classifier
`timescale 1ns/10ps
`default_nettype none
`include "psi_map.vh"
module psi_code_decode (
   // Progress byte
   input wire [7:0] code_in,
   // Classification
   output reg [3:0] phase_out,
   output wire fatal_out
);
   assign fatal_out = (code_in == `PSI_UNRECOVERABLE);
   always @* begin
      phase_out = `PSI_PH_RESERVED;
      if (code_in <= 8'h05) begin
         phase_out = `PSI_PH_SX_ENTRY;
      end else if ((code_in[3:0] == 4'h0) && (code_in >= 8'h10) && (code_in <= 8'h40)) begin
         phase_out = `PSI_PH_SX_RESUME;
      end else if ((code_in >= 8'h08) && (code_in <= 8'h0F)) begin
         phase_out = `PSI_PH_SECURITY;
      end else if ((code_in >= 8'h11) && (code_in <= 8'h1F)) begin
         phase_out = `PSI_PH_PRE_MEM_BEFORE;
      end else if ((code_in >= 8'h21) && (code_in <= 8'h29)) begin
         phase_out = `PSI_PH_MEM_INIT;
      end else if ((code_in >= 8'h2A) && (code_in <= 8'h2F)) begin
         phase_out = `PSI_PH_PRE_MEM_AFTER;
      end else if ((code_in >= 8'h31) && (code_in <= 8'h35)) begin
         phase_out = `PSI_PH_RECOVERY;
      end else if ((code_in >= 8'h36) && (code_in <= 8'h3F)) begin
         phase_out = `PSI_PH_DRIVER_EXEC;
      end else if ((code_in >= 8'h41) && (code_in <= 8'h4F)) begin
         phase_out = `PSI_PH_CPU_INIT;
      end else if ((code_in >= 8'h50) && (code_in <= 8'h5F)) begin
         // 0x50 is above the last resume code 0x40, so it is only the first bus code
         phase_out = `PSI_PH_IO_BUS;
      end else if (code_in[7:4] == 4'h6) begin
         phase_out = `PSI_PH_BOOT_SEL;
      end else if (code_in[7:4] == 4'h7) begin
         phase_out = `PSI_PH_OUTPUT_DEV;
      end else if (code_in[7:4] == 4'h9) begin
         phase_out = `PSI_PH_INPUT_DEV;
      end else if (code_in[7:4] == 4'hB) begin
         phase_out = `PSI_PH_BOOT_MEDIA;
      end
   end
endmodule // psi_code_decode
`default_nettype wire

// File: hdl/psi_post_status.v
// Post status indicator: LED blink patterns and port 80h progress holder
`timescale 1ns/10ps
`default_nettype none
`include "psi_map.vh"
module psi_post_status #(
   parameter TICK_CYCLES = `PSI_TICK_CYCLES
) (
   // Clock and reset
   input wire clock_in,
   input wire sys_rst_in,
   // Pattern requests, one-cycle pulses, and slot pin levels
   input wire req_update_in,
   input wire update_done_in,
   input wire req_video_in,
   input wire gfx_card_needed_in,
   input wire gfx_card_present_in,
   input wire req_memory_in,
   input wire req_thermal_in,
   // I/O write port
   input wire io_wr_in,
   input wire [15:0] io_addr_in,
   input wire [7:0] io_data_in,
   input wire halt_in,
   // LED and display
   output reg led_out,
   output reg [7:0] post_code_out,
   output reg [3:0] post_phase_out,
   output reg post_fatal_out,
   output reg halted_out,
   output wire [2:0] pattern_out
);
   localparam ST_IDLE = 3'h0;
   localparam ST_UPD_OFF = 3'h1;
   localparam ST_ON = 3'h2;
   localparam ST_OFF = 3'h3;
   localparam ST_PAUSE = 3'h4;

   reg [2:0] state;
   reg [2:0] pattern;
   reg [31:0] tick_cnt;
   reg [4:0] phase_ticks;
   reg [4:0] blinks;
   wire tick;
   wire [3:0] dec_phase;
   wire dec_fatal;
   wire video_ok;
   wire any_req;
   reg [2:0] next_pattern;
   reg [4:0] half;
   reg [4:0] blink_limit;
   wire [1:0] pin_raw;
   wire [1:0] pin_level;
   wire gfx_needed;
   wire gfx_present;

   // Free-running so patterns stay phase-locked to one timebase
   assign tick = (tick_cnt == (TICK_CYCLES - 1));
   always @(posedge clock_in) begin
      if (sys_rst_in) begin
         tick_cnt <= 32'h00000000;
      end else if (tick) begin
         tick_cnt <= 32'h00000000;
      end else begin
         tick_cnt <= tick_cnt + 32'h00000001;
      end
   end

   // Slot strap and presence detect are board pins, not logic on this clock.
   // A level counts once the second and third flops agree, so one-cycle glitches never start a pattern.
   assign pin_raw = {gfx_card_present_in, gfx_card_needed_in};
   genvar pin_idx;
   generate
      for (pin_idx = 0; pin_idx < 2; pin_idx = pin_idx + 1) begin : g_pin_sync
         reg meta;
         reg mid;
         reg late;
         reg level;
         always @(posedge clock_in) begin
            if (sys_rst_in) begin
               meta <= 1'b0;
               mid <= 1'b0;
               late <= 1'b0;
               level <= 1'b0;
            end else begin
               meta <= pin_raw[pin_idx];
               mid <= meta;
               late <= mid;
               if (mid == late) begin
                  level <= late;
               end
            end
         end
         assign pin_level[pin_idx] = level;
      end
   endgenerate
   assign gfx_needed = pin_level[0];
   assign gfx_present = pin_level[1];

   assign video_ok = req_video_in && gfx_needed && !gfx_present;
   assign any_req = req_update_in || video_ok || req_memory_in || req_thermal_in;
   assign pattern_out = pattern;

   // Priority among simultaneous requests: thermal, memory, video, update
   always @* begin
      next_pattern = `PSI_PAT_UPDATE;
      if (req_thermal_in) begin
         next_pattern = `PSI_PAT_THERMAL;
      end else if (req_memory_in) begin
         next_pattern = `PSI_PAT_MEMORY;
      end else if (video_ok) begin
         next_pattern = `PSI_PAT_VIDEO;
      end
   end

   always @* begin
      half = `PSI_ERR_HALF_TICKS;
      blink_limit = {2'h0, `PSI_MEMORY_BLINKS};
      case (pattern)
         `PSI_PAT_UPDATE: begin
            half = `PSI_UPD_HALF_TICKS;
            blink_limit = 5'h00;
         end
         `PSI_PAT_VIDEO: begin
            blink_limit = {2'h0, `PSI_VIDEO_BLINKS};
         end
         `PSI_PAT_MEMORY: begin
            blink_limit = {2'h0, `PSI_MEMORY_BLINKS};
         end
         `PSI_PAT_THERMAL: begin
            half = `PSI_THERM_HALF_TICKS;
            blink_limit = `PSI_THERM_FLASHES;
         end
         default: begin
            half = `PSI_ERR_HALF_TICKS;
         end
      endcase
   end

   always @(posedge clock_in) begin
      if (sys_rst_in) begin
         state <= ST_IDLE;
         pattern <= `PSI_PAT_NONE;
         phase_ticks <= 5'h00;
         blinks <= 5'h00;
         led_out <= 1'b0;
      end else if (any_req) begin
         // Restart from the first phase; partial tick counts as part of it
         pattern <= next_pattern;
         phase_ticks <= 5'h00;
         blinks <= 5'h00;
         if (next_pattern == `PSI_PAT_UPDATE) begin
            state <= ST_UPD_OFF;
            led_out <= 1'b0;
         end else begin
            state <= ST_ON;
            led_out <= 1'b1;
         end
      end else if ((pattern == `PSI_PAT_UPDATE) && update_done_in) begin
         state <= ST_IDLE;
         pattern <= `PSI_PAT_NONE;
         led_out <= 1'b0;
      end else if (tick) begin
         case (state)
            ST_UPD_OFF: begin
               if (phase_ticks == half - 5'h01) begin
                  state <= ST_ON;
                  phase_ticks <= 5'h00;
                  led_out <= 1'b1;
               end else begin
                  phase_ticks <= phase_ticks + 5'h01;
               end
            end
            ST_ON: begin
               if (phase_ticks == half - 5'h01) begin
                  state <= ST_OFF;
                  phase_ticks <= 5'h00;
                  led_out <= 1'b0;
                  blinks <= blinks + 5'h01;
               end else begin
                  phase_ticks <= phase_ticks + 5'h01;
               end
            end
            ST_OFF: begin
               if (phase_ticks == half - 5'h01) begin
                  phase_ticks <= 5'h00;
                  if (pattern == `PSI_PAT_UPDATE) begin
                     state <= ST_ON;
                     led_out <= 1'b1;
                  end else if (blinks != blink_limit) begin
                     state <= ST_ON;
                     led_out <= 1'b1;
                  end else if (pattern == `PSI_PAT_THERMAL) begin
                     state <= ST_IDLE;
                     pattern <= `PSI_PAT_NONE;
                  end else begin
                     state <= ST_PAUSE;
                  end
               end else begin
                  phase_ticks <= phase_ticks + 5'h01;
               end
            end
            ST_PAUSE: begin
               if (phase_ticks == `PSI_ERR_PAUSE_TICKS - 5'h01) begin
                  // Video and memory patterns loop until reset or a new request
                  state <= ST_ON;
                  phase_ticks <= 5'h00;
                  blinks <= 5'h00;
                  led_out <= 1'b1;
               end else begin
                  phase_ticks <= phase_ticks + 5'h01;
               end
            end
            default: begin
               state <= ST_IDLE;
               led_out <= 1'b0;
            end
         endcase
      end
   end

   psi_code_decode u_decode (
      .code_in(io_data_in),
      .phase_out(dec_phase),
      .fatal_out(dec_fatal)
   );

   always @(posedge clock_in) begin
      if (sys_rst_in) begin
         post_code_out <= 8'h00;
         post_phase_out <= `PSI_PH_SX_ENTRY;
         post_fatal_out <= 1'b0;
         halted_out <= 1'b0;
      end else begin
         if (halt_in) begin
            halted_out <= 1'b1;
         end
         // A write in the halt cycle itself still lands; later ones do not
         if (io_wr_in && (io_addr_in == `PSI_POST_PORT) && !halted_out) begin
            post_code_out <= io_data_in;
            post_phase_out <= dec_phase;
            post_fatal_out <= dec_fatal;
         end
      end
   end
endmodule // psi_post_status
`default_nettype wire

// File: shared/psi_map.vh
// Constants for the post status indicator: timings, pattern counts, port address, fatal code and phase classes
`ifndef PSI_MAP_VH
`define PSI_MAP_VH
`define PSI_CLK_HZ 100000000
`define PSI_TICK_MS 250
`define PSI_TICK_CYCLES ((`PSI_CLK_HZ / 1000) * `PSI_TICK_MS)
`define PSI_UPD_HALF_TICKS 5'h02
`define PSI_ERR_HALF_TICKS 5'h04
`define PSI_ERR_PAUSE_TICKS 5'h0A
`define PSI_VIDEO_BLINKS 3'h2
`define PSI_MEMORY_BLINKS 3'h3
`define PSI_THERM_FLASHES 5'h10
`define PSI_THERM_HALF_TICKS 5'h01
`define PSI_POST_PORT 16'h0080
`define PSI_UNRECOVERABLE 8'h5F
`define PSI_PAT_NONE 3'h0
`define PSI_PAT_UPDATE 3'h1
`define PSI_PAT_VIDEO 3'h2
`define PSI_PAT_MEMORY 3'h3
`define PSI_PAT_THERMAL 3'h4
`define PSI_PH_SX_ENTRY 4'h0
`define PSI_PH_SX_RESUME 4'h1
`define PSI_PH_SECURITY 4'h2
`define PSI_PH_PRE_MEM_BEFORE 4'h3
`define PSI_PH_MEM_INIT 4'h4
`define PSI_PH_PRE_MEM_AFTER 4'h5
`define PSI_PH_RECOVERY 4'h6
`define PSI_PH_DRIVER_EXEC 4'h7
`define PSI_PH_CPU_INIT 4'h8
`define PSI_PH_IO_BUS 4'h9
`define PSI_PH_BOOT_SEL 4'hA
`define PSI_PH_OUTPUT_DEV 4'hB
`define PSI_PH_INPUT_DEV 4'hC
`define PSI_PH_BOOT_MEDIA 4'hD
`define PSI_PH_RESERVED 4'hF
`endif

// File: verification/psi_panel_model.sv
// Front-panel LED and progress display card model
`timescale 1ns/10ps
`default_nettype none
module psi_panel_model (
   // Clock and counter clear
   input wire logic clock_in, clear_in,
   // Panel signals
   input wire logic led_in,
   input wire logic [7:0] code_in,
   output logic [7:0] flashes_out, shown_out
);
   logic prev = 1'b0;
   initial flashes_out = 8'h00;
   always @(posedge clock_in) begin
      prev <= led_in;
      if (clear_in) flashes_out <= 8'h00;
      else if (led_in && !prev) flashes_out <= flashes_out + 8'h01;
      shown_out <= code_in;
   end
endmodule // psi_panel_model
`default_nettype wire

// File: verification/psi_post_status_asserts.sv
// Checker for the post status indicator ports
`timescale 1ns/10ps
`default_nettype none
module psi_post_status_asserts #(parameter TICK_CYCLES = 4) (
   // Clock, reset and requests
   input wire logic clock_in, sys_rst_in, req_update_in, update_done_in, req_video_in,
   input wire logic gfx_card_needed_in, gfx_card_present_in, req_memory_in, req_thermal_in,
   // I/O port
   input wire logic io_wr_in, halt_in,
   input wire logic [15:0] io_addr_in,
   input wire logic [7:0] io_data_in,
   // Outputs
   input wire logic led_out, post_fatal_out, halted_out,
   input wire logic [7:0] post_code_out,
   input wire logic [3:0] post_phase_out,
   input wire logic [2:0] pattern_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   wire w80 = io_wr_in && io_addr_in == 16'h0080 && !halted_out;
   wire vid_ok = gfx_card_needed_in && !gfx_card_present_in;
   logic [1:0] pins_prev = 2'h0;
   logic [2:0] pins_quiet = 3'h0;
   // Slot pins reach the pattern logic through a filter; judge them only once settled
   always @(posedge clock_in) begin
      pins_prev <= {gfx_card_needed_in, gfx_card_present_in};
      if (pins_prev != {gfx_card_needed_in, gfx_card_present_in}) pins_quiet <= 3'h0;
      else if (pins_quiet != 3'h7) pins_quiet <= pins_quiet + 3'h1;
   end
   a_code_capture: assert property (w80 |=> post_code_out == $past(io_data_in))
      else $error("held code differs from write");
   a_halt_freeze: assert property (halted_out |=> $stable(post_code_out))
      else $error("held code moved after halt");
   a_halt_latch: assert property (halt_in |=> halted_out [*2])
      else $error("halt not latched");
   a_fatal_flag: assert property (post_fatal_out == (post_code_out == 8'h5F))
      else $error("fatal flag wrong");
   a_entry_phase: assert property (w80 && io_data_in <= 8'h05 |=> post_phase_out == 4'h0)
      else $error("entry code phase wrong");
   a_video_refused: assert property (req_video_in && !vid_ok && pins_quiet >= 3'h5 && !req_memory_in
      && !req_thermal_in && !req_update_in && pattern_out == 3'h0 |=> pattern_out == 3'h0)
      else $error("video pattern without cause");
   a_video_start: assert property (req_video_in && vid_ok && pins_quiet >= 3'h5 && !req_memory_in
      && !req_thermal_in |=> pattern_out == 3'h2 && led_out)
      else $error("video start wrong");
   a_thermal_start: assert property (req_thermal_in |=> pattern_out == 3'h4 && led_out)
      else $error("thermal start wrong");
   a_memory_start: assert property (req_memory_in && !req_thermal_in |=> pattern_out == 3'h3 && led_out)
      else $error("memory start wrong");
   a_update_start: assert property (req_update_in && !(req_memory_in || req_thermal_in || req_video_in)
      |=> pattern_out == 3'h1 && !led_out)
      else $error("update start wrong");
   cover property (req_thermal_in ##1 pattern_out == 3'h4);
   cover property (pattern_out == 3'h3 && led_out);
   cover property (pattern_out == 3'h2 && led_out);
   cover property (io_wr_in && halted_out);
endmodule // psi_post_status_asserts
bind psi_post_status psi_post_status_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.clock_in(clock_in),
   .sys_rst_in(sys_rst_in), .req_update_in(req_update_in), .update_done_in(update_done_in),
   .req_video_in(req_video_in), .gfx_card_needed_in(gfx_card_needed_in), .gfx_card_present_in(gfx_card_present_in),
   .req_memory_in(req_memory_in), .req_thermal_in(req_thermal_in), .io_wr_in(io_wr_in), .halt_in(halt_in),
   .io_addr_in(io_addr_in), .io_data_in(io_data_in), .led_out(led_out), .post_fatal_out(post_fatal_out),
   .halted_out(halted_out), .post_code_out(post_code_out), .post_phase_out(post_phase_out),
   .pattern_out(pattern_out));
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the post status indicator
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic clock_in = 0, sys_rst_in = 1, gn = 0, gp = 1, wr = 0, halt = 0, clr = 0, halted_m = 0;
   logic [4:0] rq = 5'h00;
   logic [15:0] ad = 16'h0000;
   logic [7:0] dt = 8'h00, held = 8'h00;
   wire led, fat, hlt;
   wire [7:0] code, flashes, shown;
   wire [3:0] ph;
   wire [2:0] pat;
   int mismatches = 0, checked = 0, seed = 32'h62b0, g;
   int runs[$], exp_q[$];
   initial forever #5 clock_in = ~clock_in;
   psi_post_status #(.TICK_CYCLES(4)) dut_u (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
      .req_update_in(rq[0]), .update_done_in(rq[4]), .req_video_in(rq[1]), .gfx_card_needed_in(gn),
      .gfx_card_present_in(gp), .req_memory_in(rq[2]), .req_thermal_in(rq[3]), .io_wr_in(wr),
      .io_addr_in(ad), .io_data_in(dt), .halt_in(halt), .led_out(led), .post_code_out(code),
      .post_phase_out(ph), .post_fatal_out(fat), .halted_out(hlt), .pattern_out(pat));
   psi_panel_model pm_u (.clock_in(clock_in), .clear_in(clr), .led_in(led), .code_in(code),
      .flashes_out(flashes), .shown_out(shown));
   task automatic chk(input logic [7:0] seen, input logic [7:0] want);
      checked++;
      if (seen !== want) begin
         mismatches++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic wrap_up();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Ranges in order map onto phase classes 2 upward
   function automatic logic [3:0] phase_of(input int c);
      int lo[12] = '{'h08, 'h11, 'h21, 'h2A, 'h31, 'h36, 'h41, 'h50, 'h60, 'h70, 'h90, 'hB0};
      int hi[12] = '{'h0F, 'h1F, 'h29, 'h2F, 'h35, 'h3F, 'h4F, 'h5F, 'h6F, 'h7F, 'h9F, 'hBF};
      phase_of = 4'hF;
      if (c <= 5) phase_of = 4'h0;
      else if (c % 16 == 0 && c <= 'h40) phase_of = 4'h1;
      for (int i = 0; i < 12; i++) if (c >= lo[i] && c <= hi[i]) phase_of = 4'(i + 2);
   endfunction
   task automatic pulse(input int k);
      rq[k] <= 1'b1;
      @(posedge clock_in);
      rq[k] <= 1'b0;
   endtask
   task automatic wr80(input logic [15:0] a, input logic [7:0] d);
      wr <= 1'b1; ad <= a; dt <= d;
      @(posedge clock_in);
      wr <= 1'b0;
      @(posedge clock_in);
      if (a == 16'h0080 && !halted_m) held = d;
      chk(code, held);
      chk(ph, phase_of(held));
      chk(fat, held == 8'h5F);
   endtask
   // First run is skipped: it may be cut short by the tick in progress
   task automatic measure(input int n, input logic first);
      int len, guard;
      logic prev;
      runs.delete(); len = 1; guard = 0;
      @(negedge clock_in);
      prev = led;
      chk(led, first);
      while (runs.size() < n + 1) begin
         @(negedge clock_in);
         guard++;
         if (guard > 3000) begin mismatches++; wrap_up(); end
         if (led === prev) len++;
         else begin runs.push_back(len); len = 1; prev = led; end
      end
      void'(runs.pop_front());
      @(posedge clock_in);
   endtask
   initial begin
      repeat (2) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      @(posedge clock_in);
      for (int c = 0; c < 256; c++) begin
         wr80(16'h0080, c[7:0]);
         wr80(16'($random(seed)) | 16'h0100, 8'($random(seed)));
      end
      $display("progress code test done");
      gn <= 1'b1;
      repeat (6) @(posedge clock_in);
      pulse(1);
      @(posedge clock_in);
      chk(pat, 3'h0);
      gp <= 1'b0;
      repeat (6) @(posedge clock_in);
      pulse(1);
      exp_q = '{16, 16, 56, 16, 16};
      measure(5, 1); foreach (exp_q[i]) chk(runs[i], exp_q[i]);
      chk(pat, 3'h2);
      pulse(0);
      exp_q = '{8, 8, 8};
      measure(3, 0); foreach (exp_q[i]) chk(runs[i], exp_q[i]);
      pulse(2);
      exp_q = '{16, 16, 16, 16, 56, 16};
      measure(6, 1); foreach (exp_q[i]) chk(runs[i], exp_q[i]);
      pulse(0);
      pulse(4);
      @(negedge clock_in);
      chk(pat, 3'h0);
      chk(led, 1'b0);
      $display("led pattern test done");
      @(posedge clock_in);
      clr <= 1'b1;
      @(posedge clock_in);
      clr <= 1'b0;
      pulse(3);
      exp_q = '{4, 4};
      measure(2, 1); foreach (exp_q[i]) chk(runs[i], exp_q[i]);
      for (g = 0; g < 400 && pat !== 3'h0; g++) @(posedge clock_in);
      chk(pat, 3'h0);
      if (pat !== 3'h0) wrap_up();
      chk(flashes, 8'h10);
      $display("thermal test done");
      wr80(16'h0080, 8'h5F);
      halt <= 1'b1;
      wr80(16'h0080, 8'h33);
      halted_m = 1'b1;
      halt <= 1'b0;
      wr80(16'h0080, 8'h77);
      chk(hlt, 1'b1);
      chk(shown, 8'h33);
      $display("halt test done");
      wrap_up();
   end
endmodule // testbench
`default_nettype wire
